// file: dbg_cmp_consts.svh
`ifndef DBG_CMP_CONSTS_SVH
`define DBG_CMP_CONSTS_SVH

// Register indices; byte address is four times the index
`define DBG_IDX_CMP_B_HIGH 6'h02
`define DBG_IDX_CMP_B_LOW 6'h03
`define DBG_IDX_CMP_C_HIGH 6'h04
`define DBG_IDX_CMP_C_LOW 6'h05
`define DBG_IDX_FIFO_HIGH 6'h06
`define DBG_IDX_FIFO_LOW 6'h07

// Reset value of all match bytes
`define DBG_CMP_RESET 8'h00
// Fifo high byte in event-only modes
`define DBG_FIFO_HIGH_EVENT 8'h00

// Trigger mode codes
`define DBG_TRG_A_AND_B 4'h3
`define DBG_TRG_A_AND_NOT_B 4'h4
`define DBG_TRG_EVENT_B 4'h5
`define DBG_TRG_A_THEN_EVENT_B 4'h6

`endif

// file: dbg_cmp_pkg.sv
`default_nettype none
package dbg_cmp_pkg;
  // Software-written match bytes of comparators B and C
  typedef struct packed {
    logic [7:0] b_high;
    logic [7:0] b_low;
    logic [7:0] c_high;
    logic [7:0] c_low;
  } cmp_regs_t;

  // Core bus as seen by the comparators
  typedef struct packed {
    logic [15:0] addr;
    logic [7:0] data;
  } core_bus_t;
endpackage
`default_nettype wire

// file: debug_comparator_b_c_fifo_high.sv
// Function
// - Comparator B matches address bits 15..8 to its high byte, ignored in full mode.
// - Comparator B low byte matches address bits 7..0, or data bits 7..0 in full mode.
// - Comparator C matches address bits 15..8 to its high byte, bit for bit.
// - Comparator C matches address bits 7..0 to its low byte, bit for bit.
// - Match bytes clear to zero on power-on and on any reset that is not an end-run.
// - An end-trace reset with the enable set and begin-trace clear keeps every bit.
// - The fifo high byte shows word bits 15..8, and zero for valid words in event-only modes.
// - Reading the fifo low byte advances the fifo read pointer; software reads high first.
// - Full mode means the A-and-B and A-and-not-B trigger modes, B then matching data.
`timescale 1ns/1ns
`include "dbg_cmp_consts.svh"
`default_nettype none

module debug_comparator_b_c_fifo_high #(
  parameter int ADDR_W = 8
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire dbg_cmp_pkg::core_bus_t core_bus,
  input wire logic [3:0] trigger_mode,
  input wire logic trace_reset,
  input wire logic debug_module_enable,
  input wire logic begin_trace_select,
  input wire logic [15:0] fifo_word,
  input wire logic fifo_valid,
  output logic match_b,
  output logic match_c,
  output logic fifo_advance
);

  // Bitwise equality of a byte against its match value
  function automatic logic byte_match(input logic [7:0] bus_v, input logic [7:0] want);
    byte_match = ((bus_v ^ want) == 8'h00);
  endfunction

  function automatic logic full_mode_f(input logic [3:0] mode);
    full_mode_f = (mode == `DBG_TRG_A_AND_B) || (mode == `DBG_TRG_A_AND_NOT_B);
  endfunction

  function automatic logic event_only_f(input logic [3:0] mode);
    event_only_f = (mode == `DBG_TRG_EVENT_B) || (mode == `DBG_TRG_A_THEN_EVENT_B);
  endfunction

  dbg_cmp_pkg::cmp_regs_t cmp_r;
  logic [31:0] prdata_r;
  logic pready_r;
  logic pslverr_r;
  logic match_b_r;
  logic match_c_r;
  logic fifo_advance_r;
  logic [5:0] idx;
  logic access;
  logic wr_en;
  logic rd_en;
  logic rd_req;
  logic keep_state;
  logic full_mode;
  logic mapped;

  assign idx = paddr[7:2];
  assign access = psel && penable && pready_r;
  assign wr_en = access && pwrite && (paddr[1:0] == 2'h0);
  assign rd_en = access && !pwrite && (paddr[1:0] == 2'h0);
  // First access cycle of a read: data must be loaded now to stand with pready
  assign rd_req = psel && penable && !pready_r && !pwrite && (paddr[1:0] == 2'h0);
  assign full_mode = full_mode_f(trigger_mode);
  assign keep_state = debug_module_enable && !begin_trace_select;
  assign mapped = (paddr[1:0] == 2'h0) && (idx >= `DBG_IDX_CMP_B_HIGH)
    && (idx <= `DBG_IDX_FIFO_LOW);

  // One wait state: ready rises in the second access cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_r <= 1'b0;
    end else begin
      pready_r <= psel && penable && !pready_r;
    end
  end

  // Match bytes; trace reset has priority over a concurrent write
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cmp_r <= '{`DBG_CMP_RESET, `DBG_CMP_RESET, `DBG_CMP_RESET, `DBG_CMP_RESET};
    end else if (trace_reset) begin
      if (!keep_state) begin
        cmp_r <= '{`DBG_CMP_RESET, `DBG_CMP_RESET, `DBG_CMP_RESET, `DBG_CMP_RESET};
      end
      // End-run reset: hold everything untouched
    end else if (wr_en) begin
      unique case (idx)
        `DBG_IDX_CMP_B_HIGH: cmp_r.b_high <= pwdata[7:0];
        `DBG_IDX_CMP_B_LOW: cmp_r.b_low <= pwdata[7:0];
        `DBG_IDX_CMP_C_HIGH: cmp_r.c_high <= pwdata[7:0];
        `DBG_IDX_CMP_C_LOW: cmp_r.c_low <= pwdata[7:0];
        default: ;
      endcase
    end
  end

  // Read data loaded one cycle early so it stands in the pready cycle only
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_r <= 32'h0000_0000;
      pslverr_r <= 1'b0;
    end else begin
      pslverr_r <= psel && penable && !pready_r && !mapped;
      if (rd_req) begin
        unique case (idx)
          `DBG_IDX_CMP_B_HIGH: prdata_r <= {24'h000000, cmp_r.b_high};
          `DBG_IDX_CMP_B_LOW: prdata_r <= {24'h000000, cmp_r.b_low};
          `DBG_IDX_CMP_C_HIGH: prdata_r <= {24'h000000, cmp_r.c_high};
          `DBG_IDX_CMP_C_LOW: prdata_r <= {24'h000000, cmp_r.c_low};
          `DBG_IDX_FIFO_HIGH: begin
            if (event_only_f(trigger_mode) && fifo_valid) begin
              prdata_r <= {24'h000000, `DBG_FIFO_HIGH_EVENT};
            end else begin
              prdata_r <= {24'h000000, fifo_word[15:8]};
            end
          end
          `DBG_IDX_FIFO_LOW: prdata_r <= {24'h000000, fifo_word[7:0]};
          default: prdata_r <= 32'h0000_0000;
        endcase
      end else begin
        prdata_r <= 32'h0000_0000;
      end
    end
  end

  // Low byte read pops the fifo; high byte read has no side effect
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fifo_advance_r <= 1'b0;
    end else begin
      fifo_advance_r <= rd_en && (idx == `DBG_IDX_FIFO_LOW);
    end
  end

  // Comparators, registered so downstream trigger logic sees clean levels
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      match_b_r <= 1'b0;
      match_c_r <= 1'b0;
    end else begin
      if (full_mode) begin
        match_b_r <= byte_match(core_bus.data, cmp_r.b_low);
      end else begin
        match_b_r <= byte_match(core_bus.addr[15:8], cmp_r.b_high)
          && byte_match(core_bus.addr[7:0], cmp_r.b_low);
      end
      match_c_r <= byte_match(core_bus.addr[15:8], cmp_r.c_high)
        && byte_match(core_bus.addr[7:0], cmp_r.c_low);
    end
  end

  assign prdata = prdata_r;
  assign pready = pready_r;
  assign pslverr = pslverr_r;
  assign match_b = match_b_r;
  assign match_c = match_c_r;
  assign fifo_advance = fifo_advance_r;

  // Checks
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence rd_high_s;
    rd_en && idx == `DBG_IDX_FIFO_HIGH;
  endsequence

  sequence rd_low_s;
    rd_en && idx == `DBG_IDX_FIFO_LOW;
  endsequence

  sequence wait_then_ready_s;
    psel && penable && !pready_r ##1 pready_r;
  endsequence

  cmp_b_high_a: assert property (
    (!full_mode && core_bus.addr[15:8] != cmp_r.b_high) |=> !match_b_r)
    else $error("comparator b high byte mismatch matched");

  cmp_b_addr_a: assert property (
    (!full_mode && core_bus.addr == {cmp_r.b_high, cmp_r.b_low}) |=> match_b_r)
    else $error("comparator b address match missed");

  cmp_b_data_a: assert property (
    (full_mode && core_bus.data == cmp_r.b_low) |=> match_b_r)
    else $error("comparator b data match missed in full mode");

  cmp_c_high_a: assert property (
    (core_bus.addr[15:8] != cmp_r.c_high) |=> !match_c_r)
    else $error("comparator c high byte mismatch matched");

  cmp_c_low_a: assert property (
    (core_bus.addr[7:0] != cmp_r.c_low) |=> !match_c_r)
    else $error("comparator c low byte mismatch matched");

  reset_clear_a: assert property (
    (trace_reset && !keep_state) |=> (cmp_r == '0))
    else $error("match bytes not cleared by reset");

  end_run_keep_a: assert property (
    (trace_reset && keep_state) |=> $stable(cmp_r))
    else $error("match bytes changed across end-run reset");

  fifo_high_zero_a: assert property (
    (rd_req && idx == `DBG_IDX_FIFO_HIGH && event_only_f(trigger_mode) && fifo_valid)
      |=> (prdata_r == 32'h0))
    else $error("fifo high byte not zero in event-only mode");

  fifo_pop_a: assert property (
    rd_low_s |=> fifo_advance_r ##1 !fifo_advance_r)
    else $error("fifo low read did not pulse advance once");

  high_no_pop_a: assert property (
    rd_high_s |=> !fifo_advance_r)
    else $error("fifo high read advanced the fifo");

  apb_ready_a: assert property (
    (psel && penable && !pready_r) |-> wait_then_ready_s)
    else $error("pready not raised one cycle into access");

endmodule // debug_comparator_b_c_fifo_high
`default_nettype wire

// file: core_bus_model.sv
`timescale 1ns/1ns
`default_nettype none
// CPU side of the comparators: presents one bus cycle per clock
module core_bus_model (
  input wire logic pclk,
  input wire logic presetn,
  input wire dbg_cmp_pkg::core_bus_t want,
  input wire logic data_drive,
  output dbg_cmp_pkg::core_bus_t core_bus
);
  // Undriven data flips every cycle so a stale byte never matches by luck
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      core_bus <= '0;
    end else begin
      core_bus.addr <= want.addr;
      core_bus.data <= data_drive ? want.data : ~core_bus.data;
    end
  end
endmodule // core_bus_model
`default_nettype wire

// file: tb_top.sv
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata;
  logic pready, pslverr, match_b, match_c, fifo_advance, data_drive = 1'b0;
  logic trace_reset = 1'b0, dbg_en = 1'b0, begin_sel = 1'b0, fifo_valid = 1'b1;
  logic [3:0] mode = 4'h0;
  logic [15:0] fifo_word = 16'hbeef;
  dbg_cmp_pkg::core_bus_t want = '0, core_bus;
  int err_count = 0, cmp_count = 0;
  core_bus_model core_bus_model_inst (.pclk(pclk), .presetn(presetn), .want(want),
    .data_drive(data_drive), .core_bus(core_bus));
  debug_comparator_b_c_fifo_high debug_comparator_b_c_fifo_high_inst (.pclk(pclk),
    .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .core_bus(core_bus), .trigger_mode(mode), .trace_reset(trace_reset),
    .debug_module_enable(dbg_en), .begin_trace_select(begin_sel), .fifo_word(fifo_word),
    .fifo_valid(fifo_valid), .match_b(match_b), .match_c(match_c),
    .fifo_advance(fifo_advance));
  initial begin
    forever #2 pclk = ~pclk;
  end
  task automatic tally_and_finish();
    $display("compares %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      err_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Master holds the request until pready is seen high at a rising edge
  task automatic apb(input logic wr, input logic [5:0] idx, input logic [7:0] wd,
      output logic [31:0] rd, output logic err);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= {idx, 2'b00};
    pwdata <= {24'h000000, wd};
    @(posedge pclk);
    penable <= 1'b1;
    for (n = 0; n < 20 && pready !== 1'b1; n++) @(posedge pclk);
    if (n == 20) begin
      err_count++;
      tally_and_finish();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [5:0] idx, input logic [7:0] d);
    logic [31:0] rd;
    logic e;
    apb(1'b1, idx, d, rd, e);
  endtask
  task automatic rdchk(input logic [5:0] idx, input logic [7:0] exp);
    logic [31:0] rd;
    logic e;
    apb(1'b0, idx, 8'h00, rd, e);
    chk(rd, {24'h000000, exp});
  endtask
  // Partner registers the bus, design registers the match: settle three edges
  task automatic bus(input logic [15:0] a, input logic [7:0] d, input logic [3:0] m);
    @(posedge pclk);
    want <= '{addr: a, data: d};
    mode <= m;
    data_drive <= (m == 4'h3) || (m == 4'h4);
    repeat (3) @(posedge pclk);
    #1;
  endtask
  task automatic t_reset();
    logic [31:0] rd;
    logic e;
    rdchk(6'h02, 8'h00);
    rdchk(6'h03, 8'h00);
    rdchk(6'h04, 8'h00);
    rdchk(6'h05, 8'h00);
    apb(1'b0, 6'h01, 8'h00, rd, e);
    chk(e, 1);
    $display("test reset done");
  endtask
  task automatic t_cmp_c();
    wr(6'h04, 8'h12);
    wr(6'h05, 8'h34);
    rdchk(6'h04, 8'h12);
    bus(16'h1234, 8'h00, 4'h0);
    chk(match_c, 1);
    bus(16'h9234, 8'h00, 4'h0);
    chk(match_c, 0);
    bus(16'h1235, 8'h00, 4'h0);
    chk(match_c, 0);
    $display("test comparator c done");
  endtask
  task automatic t_cmp_b();
    wr(6'h02, 8'ha5);
    wr(6'h03, 8'h5a);
    bus(16'ha55a, 8'h00, 4'h0);
    chk(match_b, 1);
    bus(16'ha45a, 8'h00, 4'h0);
    chk(match_b, 0);
    // Full modes: data against the low byte, high byte ignored
    for (int m = 3; m <= 4; m++) begin
      bus(16'h0000, 8'h5a, m[3:0]);
      chk(match_b, 1);
      bus(16'h005a, 8'h5b, m[3:0]);
      chk(match_b, 0);
    end
    $display("test comparator b done");
  endtask
  task automatic t_trace();
    @(posedge pclk);
    dbg_en <= 1'b1;
    trace_reset <= 1'b1;
    @(posedge pclk);
    trace_reset <= 1'b0;
    rdchk(6'h02, 8'ha5);
    rdchk(6'h05, 8'h34);
    begin_sel <= 1'b1;
    trace_reset <= 1'b1;
    @(posedge pclk);
    trace_reset <= 1'b0;
    rdchk(6'h02, 8'h00);
    rdchk(6'h03, 8'h00);
    $display("test trace reset done");
  endtask
  task automatic t_fifo();
    rdchk(6'h06, 8'hbe);
    #1;
    chk(fifo_advance, 0);
    @(posedge pclk);
    mode <= 4'h5;
    rdchk(6'h06, 8'h00);
    rdchk(6'h07, 8'hef);
    #1;
    chk(fifo_advance, 1);
    @(posedge pclk);
    #1;
    chk(fifo_advance, 0);
    @(posedge pclk);
    mode <= 4'h6;
    fifo_valid <= 1'b0;
    rdchk(6'h06, 8'hbe);
    fifo_valid <= 1'b1;
    rdchk(6'h06, 8'h00);
    $display("test fifo done");
  endtask
  initial begin
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_cmp_c();
    t_cmp_b();
    t_trace();
    t_fifo();
    tally_and_finish();
  end
endmodule // tb_top
`default_nettype wire
